/* File: rtl/accel_buffer_defines.vh */
// Register offsets, field positions, modes and reset values of the buffer
`ifndef ACCEL_BUFFER_DEFINES_VH
`define ACCEL_BUFFER_DEFINES_VH

// Register offsets on the plain register port
`define REG_CTRL     8'h00
`define REG_THRESH   8'h01
`define REG_LEVEL    8'h02
`define REG_STATUS   8'h03
`define REG_DATA     8'h04
`define REG_CLEAR    8'h05

// Control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_RES_BIT  2

// Status register fields
`define STAT_WM_BIT   0
`define STAT_TRIG_BIT 7

// Buffer modes
`define MODE_OLDEST  2'h0
`define MODE_STREAM  2'h1
`define MODE_TRIGGER 2'h2
`define MODE_NEWEST  2'h3

// Reset values
`define CTRL_RST     8'h00
`define THRESH_RST   7'h10

// Bytes per stored sample at each resolution
`define BYTES_HI     3'h6
`define BYTES_LO     3'h3

`endif

/* File: rtl/accel_sample_buffer.v */
// Accelerometer sample buffer: four modes, watermark, trigger capture
//
// Operation
// - Trigger mode: flag trigger on engine interrupt once threshold reached
// - Trigger mode reads oldest sample first
// - Newest-first reads start at newest Z byte
// - Watermark when stored count reaches threshold, outside trigger mode
// - Watermark holds until count below threshold
// - Store bytes singly, X_L X_H Y_L Y_H Z_L Z_H at sixteen bits, X_H Y_H Z_H at eight
// - Write pointer fills slots one after another
// - Pre-trigger at threshold discards oldest sample
// - After trigger, keep storing until full
// - Outside pre-trigger, storage continues past threshold until full
// - Oldest-first and post-trigger stop when full
// - Stream and newest-first overwrite oldest when full
// - Oldest-first read removes oldest sample
// - Newest-first read removes only newest sample
// - Eight or sixteen bits per axis stored
// - Oldest-first reads start at oldest X byte
// - Trigger event is an engine interrupt
`timescale 1ns/100ps
`include "accel_buffer_defines.vh"

module accel_sample_buffer #(
  parameter BUF_BYTES  = 256,         // Byte store size
  parameter SLOT_W     = 7,           // Sample slot index width
  parameter BA_W       = 8,           // Byte address width
  parameter FIFO_DEPTH = 4,           // Input FIFO depth
  parameter FIFO_AW    = 2            // Input FIFO pointer width
) (
  input  wire        CLK,             // System clock
  input  wire        RST_B,           // Synchronous reset, active low
  input  wire        CE,              // Clock enable
  input  wire [7:0]  ADDR,            // Register address
  input  wire [7:0]  WDATA,           // Register write data
  input  wire        WR,              // Write strobe
  input  wire        RD,              // Read strobe
  output reg  [7:0]  RDATA,           // Read data, cycle after strobe
  input  wire        SMP_VALID,       // New sample offered
  input  wire [15:0] SMP_X,           // X acceleration
  input  wire [15:0] SMP_Y,           // Y acceleration
  input  wire [15:0] SMP_Z,           // Z acceleration
  output wire        SMP_READY,       // Sample input can take one
  input  wire        TRIG_IN,         // Engine interrupt pulse
  output reg         WATERMARK,       // Watermark level
  output reg         TRIG_CAPTURED    // Trigger captured level
);

  // Sample slots that fit in the store at each resolution
  localparam [31:0]       CAP_HI_N  = BUF_BYTES / 6;  // Full-width counts
  localparam [31:0]       CAP_LO_N  = BUF_BYTES / 3;
  localparam [SLOT_W-1:0] CAP_HI    = CAP_HI_N[SLOT_W-1:0];
  localparam [SLOT_W-1:0] CAP_LO    = CAP_LO_N[SLOT_W-1:0];
  localparam [7:0]        CTRL_INIT = `CTRL_RST;       // Control at reset
  localparam              PW     = SLOT_W + 3;  // Product width

  // Configuration written by software
  reg  [1:0]        mode;             // Buffer mode
  reg               res;              // buffer_resolution_select
  reg  [6:0]        thr;              // sample_threshold_field

  // Store state
  reg  [7:0]        mem [0:BUF_BYTES-1]; // Byte store
  reg  [SLOT_W-1:0] wr_slot;          // Slot for the next sample
  reg  [SLOT_W-1:0] rd_slot;          // Oldest stored slot
  reg  [SLOT_W-1:0] count;            // Samples stored
  reg  [2:0]        rbyte;            // Bytes already read of a sample

  // Byte writer state
  reg               busy;             // A sample is being stored
  reg  [2:0]        wk;               // Byte index being stored
  reg  [47:0]       hold;             // Sample being stored

  // FIFO drain side
  wire              f_valid;          // FIFO holds a sample
  wire [47:0]       f_data;           // Oldest FIFO sample
  wire              start;            // Take a sample from the FIFO

  // Derived values
  wire [2:0]        bps;              // Bytes per sample
  wire [SLOT_W-1:0] cap;              // Slots in the store
  wire [SLOT_W-1:0] newest;           // Slot of the newest sample
  wire [PW-1:0]     bps_w;            // Bytes per sample, wide
  wire [PW-1:0]     wr_base;          // First byte of write slot
  wire [PW-1:0]     old_base;         // First byte of oldest slot
  wire [PW-1:0]     new_base;         // First byte of newest slot
  wire [PW-1:0]     lvl_w;            // Fill level in bytes, wide
  wire [7:0]        wr_byte;          // Byte to store
  wire [2:0]        new_idx;          // Newest-first byte index
  reg  [BA_W-1:0]   raddr;            // Byte address of a data read

  // Control decisions
  wire              clr;              // Buffer clear this cycle
  wire              rd_hit;           // Data byte read of a non-empty store
  wire              last_rd;          // Last byte of a sample read
  wire              pop_old;          // Oldest sample removed
  wire              pop_new;          // Newest sample removed
  wire              full;             // Every slot in use
  wire              pre_trig;         // Trigger mode, no event yet
  wire              at_thr;           // Count at or above threshold
  wire              blocked;          // New samples refused
  wire              at_end;           // Last byte being stored
  wire              commit;           // Sample becomes visible
  wire              discard;          // Oldest sample dropped
  wire              trig_set;         // Trigger event captured

  // Next values
  reg  [SLOT_W-1:0] next_count;       // Count after this cycle
  reg  [1:0]        next_mode;        // Mode after this cycle
  reg  [6:0]        next_thr;         // Threshold after this cycle

  // Input FIFO in front of the byte store
  sample_fifo #(
    .WIDTH     (48),
    .DEPTH     (FIFO_DEPTH),
    .AW        (FIFO_AW)
  ) u_fifo (
    .clk       (CLK),
    .rst_b     (RST_B),
    .ce        (CE),
    .in_valid  (SMP_VALID),
    .in_data   ({SMP_Z, SMP_Y, SMP_X}),
    .in_ready  (SMP_READY),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (start)
  );

  // Byte of the held sample in storage order
  sample_byte_pick u_pick (
    .sample    (hold),
    .hi_res    (res),
    .idx       (wk),
    .byte_out  (wr_byte)
  );

  // Slot step forward with wrap at capacity
  function [SLOT_W-1:0] slot_inc;
    input [SLOT_W-1:0] s;
    input [SLOT_W-1:0] c;
    begin
      slot_inc = (s == c - 1'b1) ? {SLOT_W{1'b0}} : s + 1'b1;
    end
  endfunction

  // Slot step back with wrap at capacity
  function [SLOT_W-1:0] slot_dec;
    input [SLOT_W-1:0] s;
    input [SLOT_W-1:0] c;
    begin
      slot_dec = (s == {SLOT_W{1'b0}}) ? c - 1'b1 : s - 1'b1;
    end
  endfunction

  // Resolution sets bytes per sample and slot count
  assign bps      = res ? `BYTES_HI : `BYTES_LO;
  assign cap      = res ? CAP_HI : CAP_LO;
  assign bps_w    = {{(PW-3){1'b0}}, bps};
  assign newest   = slot_dec(wr_slot, cap);
  assign wr_base  = {3'b000, wr_slot} * bps_w;
  assign old_base = {3'b000, rd_slot} * bps_w;
  assign new_base = {3'b000, newest} * bps_w;
  assign lvl_w    = {3'b000, count} * bps_w;

  // Newest-first walks bytes backward from Z high
  assign new_idx  = bps - 1'b1 - rbyte;

  // Register decode
  assign clr    = WR && (ADDR == `REG_CLEAR || ADDR == `REG_CTRL);
  assign rd_hit = RD && (ADDR == `REG_DATA) &&
                  (count != {SLOT_W{1'b0}});
  assign last_rd = rd_hit && (rbyte == bps - 1'b1);
  assign pop_old = last_rd && (mode != `MODE_NEWEST);
  assign pop_new = last_rd && (mode == `MODE_NEWEST);

  // Fill state
  assign full     = (count == cap);
  assign pre_trig = (mode == `MODE_TRIGGER) && !TRIG_CAPTURED;
  assign at_thr   = (count >= thr);

  // Oldest-first and post-trigger stop when full
  assign blocked = full && ((mode == `MODE_OLDEST) ||
                   ((mode == `MODE_TRIGGER) && TRIG_CAPTURED));

  // Writer takes a sample when idle, unblocked and not clearing
  assign start  = !busy && f_valid && !blocked && !clr;
  assign at_end = busy && (wk == bps - 1'b1);

  // A newest-first pop restarts the byte walk, so no commit then
  assign commit = at_end && !pop_new && !clr;

  // Drop oldest: pre-trigger at threshold, or overwrite when full
  // A threshold above capacity still may not let the store overrun
  assign discard = commit && !pop_old &&
                   (pre_trig ? (at_thr || full) : full);

  // Trigger event: engine interrupt with threshold samples held
  assign trig_set = (mode == `MODE_TRIGGER) && TRIG_IN && at_thr;

  // Byte address for a data read
  always @* begin
    raddr = {BA_W{1'b0}};
    if (mode == `MODE_NEWEST)
      raddr = new_base[BA_W-1:0] + {{(BA_W-3){1'b0}}, new_idx};
    else
      raddr = old_base[BA_W-1:0] + {{(BA_W-3){1'b0}}, rbyte};
  end

  // Count after commit, pop and discard
  always @* begin
    next_count = count;
    if (clr)
      next_count = {SLOT_W{1'b0}};
    else if (commit && !discard && !pop_old)
      next_count = count + 1'b1;
    else if (!commit && (pop_old || pop_new))
      next_count = count - 1'b1;
  end

  // Mode after a control write
  always @* begin
    next_mode = mode;
    if (WR && ADDR == `REG_CTRL)
      next_mode = WDATA[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  end

  // Threshold after a threshold write, so the watermark follows at once
  always @* begin
    next_thr = thr;
    if (WR && ADDR == `REG_THRESH)
      next_thr = WDATA[6:0];
  end

  // Configuration registers
  always @(posedge CLK) begin
    if (!RST_B) begin
      mode <= CTRL_INIT[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
      res  <= CTRL_INIT[`CTRL_RES_BIT];
      thr  <= `THRESH_RST;
    end else if (CE) begin
      if (WR && ADDR == `REG_CTRL) begin
        mode <= WDATA[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
        res  <= WDATA[`CTRL_RES_BIT];
      end
      if (WR && ADDR == `REG_THRESH)
        thr <= WDATA[6:0];
    end
  end

  // Byte writer: one byte per cycle into the write slot
  always @(posedge CLK) begin
    if (!RST_B) begin
      busy <= 1'b0;
      wk   <= 3'h0;
      hold <= 48'h0000_0000_0000;
    end else if (CE) begin
      if (clr) begin
        // Clear drops a sample in flight
        busy <= 1'b0;
        wk   <= 3'h0;
      end else if (start) begin
        busy <= 1'b1;
        wk   <= 3'h0;
        hold <= f_data;
      end else if (busy) begin
        mem[wr_base[BA_W-1:0] + {{(BA_W-3){1'b0}}, wk}] <= wr_byte;
        if (pop_new)
          // Write slot moved back; store again from the first byte
          wk <= 3'h0;
        else if (at_end) begin
          busy <= 1'b0;
          wk   <= 3'h0;
        end else
          wk <= wk + 1'b1;
      end
    end
  end

  // Slot pointers and count
  always @(posedge CLK) begin
    if (!RST_B) begin
      wr_slot <= {SLOT_W{1'b0}};
      rd_slot <= {SLOT_W{1'b0}};
      count   <= {SLOT_W{1'b0}};
    end else if (CE) begin
      count <= next_count;
      if (clr) begin
        wr_slot <= {SLOT_W{1'b0}};
        rd_slot <= {SLOT_W{1'b0}};
      end else begin
        // Next sample goes to the following slot
        if (commit)
          wr_slot <= slot_inc(wr_slot, cap);
        else if (pop_new)
          wr_slot <= newest;
        // Oldest slot leaves on a read or a discard
        if (pop_old || discard)
          rd_slot <= slot_inc(rd_slot, cap);
      end
    end
  end

  // Byte position within the sample being read
  always @(posedge CLK) begin
    if (!RST_B)
      rbyte <= 3'h0;
    else if (CE) begin
      if (clr)
        rbyte <= 3'h0;
      else if (last_rd)
        rbyte <= 3'h0;
      else if (rd_hit)
        rbyte <= rbyte + 1'b1;
    end
  end

  // Watermark and trigger flags
  always @(posedge CLK) begin
    if (!RST_B) begin
      WATERMARK     <= 1'b0;
      TRIG_CAPTURED <= 1'b0;
    end else if (CE) begin
      // Level follows count against threshold outside trigger mode
      WATERMARK <= (next_mode != `MODE_TRIGGER) &&
                   (next_count >= next_thr);
      // Event wins over a clear in the same cycle
      if (trig_set)
        TRIG_CAPTURED <= 1'b1;
      else if (clr)
        TRIG_CAPTURED <= 1'b0;
    end
  end

  // Read data, valid in the cycle after the strobe
  always @(posedge CLK) begin
    if (!RST_B)
      RDATA <= 8'h00;
    else if (CE) begin
      RDATA <= 8'h00;
      if (RD) begin
        case (ADDR)
          `REG_CTRL:   RDATA <= {5'h00, res, mode};
          `REG_THRESH: RDATA <= {1'b0, thr};
          `REG_LEVEL:  RDATA <= lvl_w[7:0];
          `REG_STATUS: RDATA <= {TRIG_CAPTURED, 6'h00, WATERMARK};
          `REG_DATA:   RDATA <= rd_hit ? mem[raddr] : 8'h00;
          default:     RDATA <= 8'h00;
        endcase
      end
    end
  end

endmodule // accel_sample_buffer

/* File: rtl/sample_byte_pick.v */
// Picks one stored byte out of a three-axis sample word
`timescale 1ns/100ps

module sample_byte_pick (
  input  wire [47:0] sample,          // {Z, Y, X}, 16 bits each
  input  wire        hi_res,          // 1: six bytes, 0: three bytes
  input  wire [2:0]  idx,             // Byte index within the sample
  output reg  [7:0]  byte_out         // Selected byte
);

  // High resolution: X_L X_H Y_L Y_H Z_L Z_H; low: upper byte per axis
  always @* begin
    byte_out = 8'h00;
    if (hi_res) begin
      case (idx)
        3'h0:    byte_out = sample[7:0];
        3'h1:    byte_out = sample[15:8];
        3'h2:    byte_out = sample[23:16];
        3'h3:    byte_out = sample[31:24];
        3'h4:    byte_out = sample[39:32];
        3'h5:    byte_out = sample[47:40];
        default: byte_out = 8'h00;
      endcase
    end else begin
      case (idx)
        3'h0:    byte_out = sample[15:8];
        3'h1:    byte_out = sample[31:24];
        3'h2:    byte_out = sample[47:40];
        default: byte_out = 8'h00;
      endcase
    end
  end

endmodule // sample_byte_pick

/* File: rtl/sample_fifo.v */
// Small valid/ready FIFO that holds whole samples ahead of the byte store
`timescale 1ns/100ps

module sample_fifo #(
  parameter WIDTH = 48,               // Word width
  parameter DEPTH = 4,                // Number of words
  parameter AW    = 2                 // Pointer width
) (
  input  wire             clk,        // System clock
  input  wire             rst_b,      // Synchronous reset, active low
  input  wire             ce,         // Clock enable
  input  wire             in_valid,   // Source offers a word
  input  wire [WIDTH-1:0] in_data,    // Offered word
  output reg              in_ready,   // Room for a word
  output wire             out_valid,  // A word waits
  output wire [WIDTH-1:0] out_data,   // Oldest word
  input  wire             out_ready   // Drain takes the word
);

  localparam [31:0] DEPTH_N  = DEPTH;           // Depth at full width
  localparam [AW:0] FULL_CNT = DEPTH_N[AW:0];   // Fill count when full

  reg [WIDTH-1:0] mem [0:DEPTH-1];    // Word storage
  reg [AW-1:0]    wptr;               // Next write slot
  reg [AW-1:0]    rptr;               // Next read slot
  reg [AW:0]      cnt;                // Words held
  wire            push = in_valid && in_ready;   // Word accepted
  wire            pop  = out_valid && out_ready; // Word drained
  reg  [AW:0]     next_cnt;           // Count after this cycle

  assign out_valid = (cnt != {(AW+1){1'b0}});
  assign out_data  = mem[rptr];

  // Next fill count
  always @* begin
    next_cnt = cnt;
    if (push && !pop)
      next_cnt = cnt + 1'b1;
    else if (pop && !push)
      next_cnt = cnt - 1'b1;
  end

  // Pointers, count and registered ready
  always @(posedge clk) begin
    if (!rst_b) begin
      wptr     <= {AW{1'b0}};
      rptr     <= {AW{1'b0}};
      cnt      <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
    end else if (ce) begin
      if (push) begin
        mem[wptr] <= in_data;
        wptr      <= (wptr == DEPTH - 1) ? {AW{1'b0}} : wptr + 1'b1;
      end
      if (pop)
        rptr <= (rptr == DEPTH - 1) ? {AW{1'b0}} : rptr + 1'b1;
      cnt      <= next_cnt;
      in_ready <= (next_cnt != FULL_CNT);
    end
  end

endmodule // sample_fifo

/* File: test/accel_sample_buffer_props.sv */
// Port checker of the sample buffer and its bind
`timescale 1ns/100ps
`include "accel_buffer_defines.vh"

module accel_sample_buffer_props (
  input wire       CLK,            // System clock
  input wire       RST_B,          // Synchronous reset
  input wire       CE,             // Clock enable
  input wire [7:0] ADDR,           // Register address
  input wire [7:0] WDATA,          // Write data
  input wire       WR,             // Write strobe
  input wire       RD,             // Read strobe
  input wire [7:0] RDATA,          // Read data
  input wire       SMP_VALID,      // Sample offered
  input wire       SMP_READY,      // Sample input ready
  input wire       TRIG_IN,        // Engine interrupt
  input wire       WATERMARK,      // Watermark level
  input wire       TRIG_CAPTURED   // Trigger captured level
);
  reg  [1:0] mode;                 // Mode as last written
  reg        res;                  // Resolution as last written
  reg  [6:0] thresh;               // Threshold as last written
  wire       wr_ok = WR && CE;     // Write taken

  // Shadow of the control and threshold fields
  always @(posedge CLK) begin
    if (!RST_B) begin
      mode   <= 2'h0;
      res    <= 1'b0;
      thresh <= `THRESH_RST;
    end else if (wr_ok && ADDR == `REG_CTRL) begin
      mode <= WDATA[1:0];
      res  <= WDATA[2];
    end else if (wr_ok && ADDR == `REG_THRESH) begin
      thresh <= WDATA[6:0];
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  AST_TRIG_SET: assert property (
    $rose(TRIG_CAPTURED) |-> $past(TRIG_IN) && $past(mode) == `MODE_TRIGGER)
    else $error("trigger flag set without cause");
  AST_TRIG_CLR: assert property (
    $fell(TRIG_CAPTURED) |-> $past(WR))
    else $error("trigger flag dropped without a write");
  AST_CLEAR: assert property (
    $past(wr_ok && ADDR == `REG_CLEAR && !TRIG_IN) |-> !TRIG_CAPTURED &&
      WATERMARK == (thresh == 7'h00 && mode != `MODE_TRIGGER))
    else $error("clear left flags standing");
  AST_WM_TRIG: assert property (
    mode == `MODE_TRIGGER |-> !WATERMARK)
    else $error("watermark raised in trigger mode");
  AST_WM_FALL: assert property (
    $fell(WATERMARK) |-> $past(RD || WR))
    else $error("watermark dropped without access");
  AST_STATUS: assert property (
    $past(RD && CE && ADDR == `REG_STATUS) |->
      RDATA == {$past(TRIG_CAPTURED), 6'h00, $past(WATERMARK)})
    else $error("status read differs from flags");
  AST_LEVEL: assert property (
    $past(RD && CE && ADDR == `REG_LEVEL) |->
      RDATA % ($past(res) ? 8'h06 : 8'h03) == 8'h00)
    else $error("level not whole samples");
  AST_READY: assert property (
    $fell(SMP_READY) |-> $past(SMP_VALID, 1) || $past(SMP_VALID, 2))
    else $error("sample input refused without traffic");
endmodule // accel_sample_buffer_props

bind accel_sample_buffer accel_sample_buffer_props props (
  .CLK(CLK), .RST_B(RST_B), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .SMP_VALID(SMP_VALID), .SMP_READY(SMP_READY),
  .TRIG_IN(TRIG_IN), .WATERMARK(WATERMARK), .TRIG_CAPTURED(TRIG_CAPTURED));

/* File: test/accel_sample_buffer_tb_top.sv */
// Self-checking bench of the sample buffer
`timescale 1ns/100ps
`include "accel_buffer_defines.vh"

module accel_sample_buffer_tb_top;
  typedef struct packed {
    logic [1:0] mode;              // Buffer mode
    logic       res;               // Resolution select
    logic       newest;            // Reads start at newest sample
    logic [7:0] lvl;               // Level after one sample read
  } row_t;
  reg          clk = 1'b0;         // System clock
  reg          rst_b = 1'b0;       // Reset, active low
  reg          smp_valid = 1'b0;   // Sample offered
  reg          trig_in = 1'b0;     // Engine interrupt
  reg   [47:0] threshold_sample_count = 48'h0;        // Offered sample {Z, Y, X}
  reg   [7:0]  d;                  // Read result
  wire  [7:0]  addr, wdata, rdata; // Register port
  wire         wr, rd, smp_ready, watermark, trig_captured;
  int          failures = 0;       // Mismatches
  int          n_compared = 0;     // Comparisons
  row_t rows [8] = '{'{2'h0, 1'b1, 1'b0, 8'h06}, '{2'h0, 1'b0, 1'b0, 8'h03},
    '{2'h1, 1'b1, 1'b0, 8'h06}, '{2'h1, 1'b0, 1'b0, 8'h03},
    '{2'h2, 1'b1, 1'b0, 8'h06}, '{2'h2, 1'b0, 1'b0, 8'h03},
    '{2'h3, 1'b1, 1'b1, 8'h06}, '{2'h3, 1'b0, 1'b1, 8'h03}};

  // 40 MHz clock
  always #12.5 clk = ~clk;

  accel_sample_buffer dut (.CLK(clk), .RST_B(rst_b), .CE(1'b1), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SMP_VALID(smp_valid),
    .SMP_X(threshold_sample_count[15:0]), .SMP_Y(threshold_sample_count[31:16]), .SMP_Z(threshold_sample_count[47:32]),
    .SMP_READY(smp_ready), .TRIG_IN(trig_in), .WATERMARK(watermark),
    .TRIG_CAPTURED(trig_captured));
  host_port_model host (.CLK(clk), .RDATA(rdata), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd));

  // Byte comparison, flags passed widened
  task cmp(input string name, input [7:0] exp, input [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Distinct sample per index
  function [47:0] smp_of(input [7:0] n);
    smp_of = {8'h66 ^ n, 8'h55, 8'h44 ^ n, 8'h33, 8'h22 ^ n, 8'h11};
  endfunction

  // Expected i-th byte read out of sample s
  function [7:0] exp_byte(input [47:0] s, input hr, input nw, input [2:0] i);
    reg [2:0] k;
    k = nw ? (hr ? 3'h5 - i : 3'h2 - i) : i;
    exp_byte = hr ? s[8*k +: 8] : s[16*k+8 +: 8];
  endfunction

  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Offer one sample and hold it until ready is seen high after an edge, or 60 edges pass
  task push(input [7:0] n);
    int t;
    t = 0;
    threshold_sample_count       <= smp_of(n);
    smp_valid <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (smp_ready !== 1'b1 && t < 60);
    // Let an edge pass so a following push never re-drives valid at once
    smp_valid <= 1'b0;
    @(posedge clk);
    if (t >= 60)
      cmp("sample taken", 8'h01, {7'h00, smp_ready});
  endtask

  // Read one whole sample and compare every byte
  task rd_sample(input [47:0] s, input hr, input nw);
    for (int i = 0; i < (hr ? 6 : 3); i++) begin
      host.rd(`REG_DATA, d);
      cmp("data", exp_byte(s, hr, nw, i), d);
    end
  endtask

  task setup(input [1:0] m, input r, input [6:0] th);
    host.wr(`REG_THRESH, {1'b0, th});
    host.wr(`REG_CTRL, {5'h00, r, m});
  endtask

  task pulse_trig;
    trig_in <= 1'b1;
    @(posedge clk);
    trig_in <= 1'b0;
    idle(2);
  endtask

  task conclude;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #500000;
    failures++;
    conclude;
  end

  // Main sequence
  initial begin
    idle(2);
    rst_b <= 1'b1;
    host.wr(8'h3A, 8'hFF);
    host.rd(`REG_CTRL, d);
    cmp("ctrl", `CTRL_RST, d);
    host.rd(`REG_THRESH, d);
    cmp("thresh", {1'b0, `THRESH_RST}, d);
    host.rd(`REG_DATA, d);
    cmp("empty data", 8'h00, d);
    host.rd(8'h3A, d);
    cmp("unmapped", 8'h00, d);
    // Table of mode and resolution cases
    foreach (rows[r]) begin
      setup(rows[r].mode, rows[r].res, 7'h10);
      push(8'h01);
      push(8'h02);
      idle(20);
      rd_sample(smp_of(rows[r].newest ? 8'h02 : 8'h01), rows[r].res,
                rows[r].newest);
      host.rd(`REG_LEVEL, d);
      cmp("level", rows[r].lvl, d);
    end
    // Watermark at threshold three
    setup(`MODE_OLDEST, 1'b1, 7'h03);
    push(8'h01);
    push(8'h02);
    idle(20);
    cmp("wm below", 8'h00, {7'h00, watermark});
    push(8'h03);
    push(8'h04);
    idle(20);
    cmp("wm at", 8'h01, {7'h00, watermark});
    host.rd(`REG_LEVEL, d);
    cmp("level past", 8'h18, d);
    rd_sample(smp_of(8'h01), 1'b1, 1'b0);
    cmp("wm held", 8'h01, {7'h00, watermark});
    rd_sample(smp_of(8'h02), 1'b1, 1'b0);
    cmp("wm gone", 8'h00, {7'h00, watermark});
    // Oldest-first fills, stalls, keeps oldest
    setup(`MODE_OLDEST, 1'b1, 7'h10);
    for (int n = 0; n < 46; n++)
      push(n[7:0]);
    idle(20);
    cmp("ready full", 8'h00, {7'h00, smp_ready});
    host.rd(`REG_LEVEL, d);
    cmp("level full", 8'hFC, d);
    rd_sample(smp_of(8'h00), 1'b1, 1'b0);
    // Stream overwrites oldest
    setup(`MODE_STREAM, 1'b1, 7'h10);
    for (int n = 0; n < 43; n++)
      push(n[7:0]);
    // FIFO and writer may still hold five samples at seven cycles each
    idle(60);
    rd_sample(smp_of(8'h01), 1'b1, 1'b0);
    // Newest-first pops newest, keeps older
    setup(`MODE_NEWEST, 1'b1, 7'h10);
    push(8'h01);
    push(8'h02);
    push(8'h03);
    idle(20);
    rd_sample(smp_of(8'h03), 1'b1, 1'b1);
    rd_sample(smp_of(8'h02), 1'b1, 1'b1);
    // Trigger with threshold two
    setup(`MODE_TRIGGER, 1'b1, 7'h02);
    push(8'h00);
    idle(20);
    pulse_trig;
    cmp("trig early", 8'h00, {7'h00, trig_captured});
    for (int n = 1; n < 4; n++)
      push(n[7:0]);
    idle(20);
    host.rd(`REG_LEVEL, d);
    cmp("level pre", 8'h0C, d);
    pulse_trig;
    cmp("trig set", 8'h01, {7'h00, trig_captured});
    push(8'h04);
    push(8'h05);
    idle(20);
    host.rd(`REG_LEVEL, d);
    cmp("level post", 8'h18, d);
    rd_sample(smp_of(8'h02), 1'b1, 1'b0);
    host.wr(`REG_CLEAR, 8'h00);
    host.rd(`REG_STATUS, d);
    cmp("status clr", 8'h00, d);
    host.rd(`REG_LEVEL, d);
    cmp("level clr", 8'h00, d);
    // Reset in mid-run with trigger captured
    push(8'h06);
    push(8'h07);
    idle(20);
    pulse_trig;
    rst_b <= 1'b0;
    idle(2);
    rst_b <= 1'b1;
    idle(1);
    cmp("trig rst", 8'h00, {7'h00, trig_captured});
    cmp("ready rst", 8'h01, {7'h00, smp_ready});
    conclude;
  end
endmodule // accel_sample_buffer_tb_top

/* File: test/host_port_model.sv */
// Register-port master standing in for the host processor
`timescale 1ns/100ps

module host_port_model (
  input  wire       CLK,    // System clock
  input  wire [7:0] RDATA,  // Read data from the buffer
  output reg  [7:0] ADDR,   // Register address
  output reg  [7:0] WDATA,  // Write data
  output reg        WR,     // Write strobe
  output reg        RD      // Read strobe
);
  // Quiet bus from time zero
  initial begin
    ADDR  = 8'h00;
    WDATA = 8'h00;
    WR    = 1'b0;
    RD    = 1'b0;
  end

  // One-cycle write; address and data scrambled once released
  task wr(input [7:0] a, input [7:0] v);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
    ADDR  <= ~a;
    WDATA <= ~v;
    @(posedge CLK);
  endtask

  // One-cycle read; answer taken at the following edge
  task rd(input [7:0] a, output [7:0] v);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    ADDR <= ~a;
    @(posedge CLK);
    v = RDATA;
  endtask
endmodule // host_port_model
